// ==== src/ims_baud.sv ====
// reloading baud counter that times each half period of the serial clock
`timescale 1ns/1ps
module ims_baud
  import ims_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [15:0] reload,
  output logic tick
);

  logic [16:0] cnt;
  logic [16:0] load;

  // a half period lasts reload + 2 cycles, so the full period is twice that
  assign load = {1'b0, reload} + 17'h00001;
  assign tick = run && (cnt == 17'h00000);

  // every half period is one full count; the counter reloads on each tick
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 17'h00000;
    else if (!run || tick)
      cnt <= load;
    else
      cnt <= cnt - 17'h00001;
  end

endmodule

// ==== src/ims_ctrl.sv ====
// I2C master and slave controller with classic Wishbone register access
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// - transmit write reloads and starts baud counter
// - serial clock equals clock over 2*(reload+2)
// - general call accepted only when enabled
// - stretch enable lets slave hold clock
// - ack value picks ACK or NACK
// - ack request drives ack on bus
// - receive request clocks one byte, self-clears
// - stop request makes Stop, then clears
// - restart request makes Repeated Start, clears
// - start request makes Start, then clears
// - hold select sets data hold time
// - address/data hold clears release, holds clock
// - clock held low suspends; release resumes
// - 7/10-bit addressing, arbitration, collision detect
module ims_ctrl
  import ims_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic evt_master,
  output logic evt_slave,
  output logic evt_collision
);

  ims_ctrl_s ctrl, next_ctrl;
  ims_opts_s opts;
  logic [15:0] baud_reload_value, slave_address, status;
  logic [7:0] transmit_byte_register, receive_buffer, rx_data, adr;
  logic rx_full, receive_overflow_flag, bus_collision_flag, ack_status, start_seen, stop_seen, gencall_seen;
  logic wb_req, wb_wr, wb_rd, tx_write;
  ims_mstate_e m_state;
  ims_xfer_e m_xfer;
  logic [3:0] m_cnt, m_len;
  logic [7:0] m_sh;
  logic m_park, m_owner, m_scl_low, m_sda_low, m_bit, m_run, m_tick, m_last, m_coll, m_seq_done, m_done;
  ims_sstate_e s_state;
  logic [3:0] s_cnt;
  logic [7:0] s_sh;
  logic s_read, s_lo_next, s_hi_ok, s_ack_low, s_hold_ack, s_nack, s_sda_low, s_ack_drive, s_coll;
  logic s_byte_done, s_gc, s_m7, s_lo, s_hi_rd, s_part, s_full, s_take, s_upd, s_hold, s_to_tx, rel_clr;
  logic scl_prev, sda_prev, scl_rise, scl_fall, bus_start, bus_stop, bus_busy, rx_wr;
  logic [6:0] hold_cnt;

  // ---------------- Wishbone slave: one wait state, ack for one cycle ----------------
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wb_rd = wb_req && !wb_we_i;
  assign tx_write = wb_wr && (adr == ADDR_TX) && wb_sel_i[0];

  always_comb
  begin
    status = 16'h0000;
    status[ST_MASTER_BUSY] = (m_state != M_IDLE);
    status[ST_RX_FULL] = rx_full;
    status[ST_ACK_STATUS] = ack_status;
    status[ST_START_SEEN] = start_seen;
    status[ST_STOP_SEEN] = stop_seen;
    status[ST_SLAVE_READ] = s_read;
    status[ST_OVERFLOW] = receive_overflow_flag;
    status[ST_GENCALL] = gencall_seen;
    status[ST_BUS_BUSY] = bus_busy;
    status[ST_SLAVE_ACTIVE] = (s_state != S_IDLE);
    status[ST_COLLISION] = bus_collision_flag;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_rd)
        unique case (adr)
          ADDR_CTRL: wb_dat_o <= {16'h0000, ctrl};
          ADDR_OPTS: wb_dat_o <= {16'h0000, opts};
          ADDR_BAUD: wb_dat_o <= {16'h0000, baud_reload_value};
          ADDR_TX: wb_dat_o <= {24'h000000, transmit_byte_register};
          ADDR_RX: wb_dat_o <= {24'h000000, receive_buffer};
          ADDR_STAT: wb_dat_o <= {16'h0000, status};
          ADDR_SADDR: wb_dat_o <= {16'h0000, slave_address};
          default: wb_dat_o <= 32'h00000000;
        endcase
    end
  end

  always_comb
  begin
    next_ctrl = ctrl;
    if (wb_wr && adr == ADDR_CTRL)
      next_ctrl = ims_ctrl_s'(merge16(ctrl, wb_dat_i, wb_sel_i, CTRL_WMASK));
    if (m_seq_done || m_coll)
    begin
      next_ctrl.start_request = 1'b0;
      next_ctrl.restart_request = 1'b0;
    end
    if ((m_tick && m_state == M_P3) || m_coll)
      next_ctrl.stop_request = 1'b0;
    if ((m_done && m_xfer == X_RX) || m_coll)
      next_ctrl.receive_byte_request = 1'b0;
    if ((m_done && m_xfer == X_ACK) || m_coll)
      next_ctrl.ack_sequence_request = 1'b0;
    if (rel_clr)
      next_ctrl.clock_release = 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= ims_ctrl_s'(CTRL_RESET);
      opts <= ims_opts_s'(OPTS_RESET);
      baud_reload_value <= BAUD_RESET;
      slave_address <= SADDR_RESET;
      transmit_byte_register <= 8'h00;
    end
    else
    begin
      ctrl <= next_ctrl;
      if (wb_wr && adr == ADDR_OPTS)
        opts <= ims_opts_s'(merge16(opts, wb_dat_i, wb_sel_i, OPTS_WMASK));
      if (wb_wr && adr == ADDR_BAUD)
        baud_reload_value <= merge16(baud_reload_value, wb_dat_i, wb_sel_i, BAUD_WMASK);
      if (wb_wr && adr == ADDR_SADDR)
        slave_address <= merge16(slave_address, wb_dat_i, wb_sel_i, SADDR_WMASK);
      if (tx_write)
        transmit_byte_register <= wb_dat_i[7:0];
    end
  end

  // sticky flags: a hardware set in the cycle of a clear wins
  assign rx_wr = (m_done && m_xfer == X_RX) || s_upd;
  assign rx_data = (m_done && m_xfer == X_RX) ? {m_sh[6:0], sda_i} : s_sh;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      receive_buffer <= 8'h00;
      rx_full <= 1'b0;
      receive_overflow_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      gencall_seen <= 1'b0;
    end
    else
    begin
      if (rx_wr)
        receive_buffer <= rx_data;
      if (rx_wr)
        rx_full <= 1'b1;
      else if (wb_rd && adr == ADDR_RX)
        rx_full <= 1'b0;
      if (((m_done && m_xfer == X_RX) || s_take) && rx_full)
        receive_overflow_flag <= 1'b1;
      else if (wb_wr && adr == ADDR_STAT && wb_sel_i[0] && wb_dat_i[ST_OVERFLOW])
        receive_overflow_flag <= 1'b0;
      if (m_coll || s_coll)
        bus_collision_flag <= 1'b1;
      else if (wb_wr && adr == ADDR_STAT && wb_sel_i[1] && wb_dat_i[ST_COLLISION])
        bus_collision_flag <= 1'b0;
      if (bus_start)
        start_seen <= 1'b1;
      else if (wb_wr && adr == ADDR_STAT && wb_sel_i[0] && wb_dat_i[ST_START_SEEN])
        start_seen <= 1'b0;
      if (bus_stop)
        stop_seen <= 1'b1;
      else if (wb_wr && adr == ADDR_STAT && wb_sel_i[0] && wb_dat_i[ST_STOP_SEEN])
        stop_seen <= 1'b0;
      if (s_take && s_gc)
        gencall_seen <= 1'b1;
      else if (wb_wr && adr == ADDR_STAT && wb_sel_i[0] && wb_dat_i[ST_GENCALL])
        gencall_seen <= 1'b0;
    end
  end

  // ---------------- bus watch: conditions and edges ----------------
  assign scl_rise = !scl_prev && scl_i;
  assign scl_fall = scl_prev && !scl_i;
  assign bus_start = scl_i && scl_prev && sda_prev && !sda_i;
  assign bus_stop = scl_i && scl_prev && !sda_prev && sda_i;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bus_busy <= 1'b0;
    end
    else
    begin
      scl_prev <= scl_i;
      sda_prev <= sda_i;
      if (bus_start)
        bus_busy <= 1'b1;
      else if (bus_stop)
        bus_busy <= 1'b0;
    end
  end

  // ---------------- master sequencer ----------------
  ims_baud u_baud (
    .clock(clock),
    .arst_n(arst_n),
    .run(m_run),
    .reload(baud_reload_value),
    .tick(m_tick)
  );

  assign m_len = (m_xfer == X_TX) ? TX_BITS : ((m_xfer == X_RX) ? DATA_BITS : ACK_BITS);
  assign m_last = (m_cnt == m_len - 4'h1);
  assign m_bit = (m_xfer == X_TX) ? (m_cnt >= DATA_BITS || m_sh[7]) : ((m_xfer == X_RX) || ctrl.ack_value);
  // a released clock held low by another party stops the count
  // our own pull is registered, so its last cycle still counts and a half period stays reload + 2
  assign m_run = (m_state != M_IDLE) && (m_scl_low || scl_oe || scl_i);
  assign m_seq_done = m_tick && (m_state == M_S2);
  assign m_done = m_tick && (m_state == M_HI) && m_last;
  // arbitration lost while sending a one, or start asked on a bus owned by another master
  assign m_coll = (m_tick && m_state == M_HI && m_xfer == X_TX && m_cnt < DATA_BITS && !sda_oe && !sda_i)
               || (m_state == M_IDLE && ctrl.start_request && bus_busy && !m_owner);

  always_comb
  begin
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
    unique case (m_state)
      M_IDLE: m_scl_low = m_park;
      M_S1: m_sda_low = 1'b1;
      M_S2:
      begin
        m_scl_low = 1'b1;
        m_sda_low = 1'b1;
      end
      M_R1: m_scl_low = 1'b1;
      M_R2: m_sda_low = 1'b0;
      M_R3: m_sda_low = 1'b1;
      M_P1:
      begin
        m_scl_low = 1'b1;
        m_sda_low = 1'b1;
      end
      M_P2: m_sda_low = 1'b1;
      M_P3: m_sda_low = 1'b0;
      M_LO:
      begin
        m_scl_low = 1'b1;
        m_sda_low = !m_bit;
      end
      M_HI: m_sda_low = !m_bit;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      m_state <= M_IDLE;
      m_xfer <= X_TX;
      m_cnt <= 4'h0;
      m_sh <= 8'h00;
      m_park <= 1'b0;
      m_owner <= 1'b0;
      ack_status <= 1'b0;
    end
    else if (!ctrl.enable || m_coll)
    begin
      m_state <= M_IDLE;
      m_park <= 1'b0;
      m_owner <= 1'b0;
    end
    else
      unique case (m_state)
        M_IDLE:
        begin
          m_cnt <= 4'h0;
          if (ctrl.stop_request)
            m_state <= M_P1;
          else if (ctrl.restart_request)
            m_state <= M_R1;
          else if (ctrl.start_request)
            m_state <= M_S1;
          else if (ctrl.ack_sequence_request)
          begin
            m_xfer <= X_ACK;
            m_state <= M_LO;
          end
          else if (ctrl.receive_byte_request)
          begin
            m_xfer <= X_RX;
            m_state <= M_LO;
          end
          else if (tx_write && m_owner)
          begin
            m_xfer <= X_TX;
            m_sh <= wb_dat_i[7:0];
            m_state <= M_LO; // leaving idle starts the baud count
          end
        end
        M_S1: if (m_tick) m_state <= M_S2;
        M_S2:
          if (m_tick)
          begin
            m_state <= M_IDLE;
            m_park <= 1'b1;
            m_owner <= 1'b1;
          end
        M_R1: if (m_tick) m_state <= M_R2;
        M_R2: if (m_tick) m_state <= M_R3;
        M_R3: if (m_tick) m_state <= M_S2;
        M_P1: if (m_tick) m_state <= M_P2;
        M_P2: if (m_tick) m_state <= M_P3;
        M_P3:
          if (m_tick)
          begin
            m_state <= M_IDLE;
            m_park <= 1'b0;
            m_owner <= 1'b0;
          end
        M_LO: if (m_tick) m_state <= M_HI;
        M_HI:
          if (m_tick)
          begin
            if (m_xfer != X_ACK && m_cnt < DATA_BITS)
              m_sh <= {m_sh[6:0], sda_i};
            if (m_xfer == X_TX && m_cnt == DATA_BITS)
              ack_status <= sda_i;
            m_cnt <= m_cnt + 4'h1;
            m_state <= m_last ? M_IDLE : M_LO;
          end
      endcase
  end

  // ---------------- slave engine ----------------
  assign s_byte_done = scl_fall && s_cnt == DATA_BITS && (s_state == S_ADDR || s_state == S_RXD);
  assign s_gc = ctrl.general_call_enable && s_sh == GENERAL_CALL_ADDR && !s_lo_next;
  assign s_m7 = !ctrl.ten_bit && s_sh[7:1] == slave_address[6:0];
  assign s_lo = s_lo_next && s_sh == slave_address[7:0];
  assign s_hi_rd = ctrl.ten_bit && s_hi_ok && s_sh == {TEN_BIT_PREFIX, slave_address[9:8], 1'b1};
  assign s_part = ctrl.ten_bit && !s_lo_next && s_sh == {TEN_BIT_PREFIX, slave_address[9:8], 1'b0};
  assign s_full = s_gc || s_m7 || s_lo || s_hi_rd;
  assign s_take = s_byte_done && (s_state == S_RXD || s_full || s_part);
  assign s_upd = s_take && (opts.buffer_overwrite_enable || !receive_overflow_flag);
  assign s_hold = (s_state == S_ADDR) ? opts.address_hold_enable : opts.data_hold_enable;
  assign s_ack_drive = s_hold_ack ? !ctrl.ack_value : s_ack_low;
  assign s_to_tx = scl_fall && ((s_state == S_ACK && s_ack_drive && s_read && !s_lo_next)
                             || (s_state == S_MACK && !s_nack));
  assign rel_clr = (s_to_tx && ctrl.stretch_enable) || (s_take && s_hold);
  assign s_coll = opts.slave_collision_detect_enable && scl_rise && (s_state == S_TXD || s_state == S_ACK)
               && !sda_oe && !sda_i;
  assign s_sda_low = (s_state == S_ACK) ? s_ack_drive
                   : ((s_state == S_TXD) && s_cnt < DATA_BITS && !transmit_byte_register[3'(4'h7 - s_cnt)]);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_state <= S_IDLE;
      s_cnt <= 4'h0;
      s_sh <= 8'h00;
      s_read <= 1'b0;
      s_lo_next <= 1'b0;
      s_hi_ok <= 1'b0;
      s_ack_low <= 1'b0;
      s_hold_ack <= 1'b0;
      s_nack <= 1'b0;
    end
    else if (!ctrl.enable || bus_stop)
    begin
      s_state <= S_IDLE;
      s_lo_next <= 1'b0;
      s_hi_ok <= 1'b0;
    end
    else if (bus_start)
    begin
      s_state <= S_ADDR;
      s_cnt <= 4'h0;
      s_lo_next <= 1'b0;
    end
    else if (s_coll)
      s_state <= S_IDLE;
    else if (scl_rise)
    begin
      if (s_state == S_ADDR || s_state == S_RXD)
        s_sh <= {s_sh[6:0], sda_i};
      if (s_state == S_ADDR || s_state == S_RXD || s_state == S_TXD)
        s_cnt <= s_cnt + 4'h1;
      if (s_state == S_MACK)
        s_nack <= sda_i;
    end
    else if (scl_fall)
      unique case (s_state)
        S_ADDR, S_RXD:
          if (s_cnt == DATA_BITS)
          begin
            s_state <= s_take ? S_ACK : S_IDLE;
            s_ack_low <= s_upd;
            s_hold_ack <= s_hold;
            if (s_state == S_ADDR && s_take)
            begin
              s_read <= s_sh[0] && !s_gc;
              s_lo_next <= s_part;
              if (s_lo)
                s_hi_ok <= 1'b1;
            end
          end
        S_ACK:
        begin
          s_cnt <= 4'h0;
          if (!s_ack_drive)
            s_state <= S_IDLE;
          else if (s_lo_next)
            s_state <= S_ADDR;
          else
            s_state <= s_read ? S_TXD : S_RXD;
        end
        S_TXD: if (s_cnt == DATA_BITS) s_state <= S_MACK;
        S_MACK:
        begin
          s_cnt <= 4'h0;
          s_state <= s_nack ? S_IDLE : S_TXD;
        end
        default: ;
      endcase
  end

  // ---------------- pin drivers and events ----------------
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      hold_cnt <= 7'h00;
      evt_master <= 1'b0;
      evt_slave <= 1'b0;
      evt_collision <= 1'b0;
    end
    else
    begin
      // the master pulls the clock as its state asks; the slave holds it low until software releases it
      scl_oe <= ctrl.enable && (m_scl_low || (s_state != S_IDLE && !ctrl.clock_release));
      if (scl_fall)
        hold_cnt <= opts.hold_time_select ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
      else if (hold_cnt != 7'h00)
        hold_cnt <= hold_cnt - 7'h01;
      // data may change only after the hold time with the clock low, except in start/stop edges
      if (!ctrl.enable)
        sda_oe <= 1'b0;
      else if ((!scl_i && !scl_fall && hold_cnt == 7'h00) || m_state == M_S1 || m_state == M_R3 || m_state == M_P3)
        sda_oe <= m_sda_low || s_sda_low;
      evt_master <= m_seq_done || (m_tick && m_state == M_P3) || m_done;
      evt_slave <= (s_take && (s_full || s_state == S_RXD)) || (scl_fall && s_state == S_MACK)
                || (bus_start && opts.start_irq_enable)
                || (bus_stop && opts.stop_irq_enable);
      evt_collision <= m_coll || s_coll;
    end
  end

endmodule

// ==== src/ims_pkg.sv ====
// shared constants, register layouts and state types of the I2C controller
package ims_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int HOLD_SHORT_NS = 100;
  localparam int HOLD_LONG_NS = 300;
  // least times round up to whole clock cycles
  localparam logic [6:0] HOLD_SHORT_CYC = 7'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] HOLD_LONG_CYC = 7'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPTS = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TX = 8'h0C;
  localparam logic [7:0] ADDR_RX = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_SADDR = 8'h18;

  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_WMASK = 16'h92FF;
  localparam logic [15:0] OPTS_RESET = 16'h0000;
  localparam logic [15:0] OPTS_WMASK = 16'h007F;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [15:0] BAUD_WMASK = 16'hFFFF;
  localparam logic [15:0] SADDR_RESET = 16'h0000;
  localparam logic [15:0] SADDR_WMASK = 16'h03FF;

  localparam int ST_MASTER_BUSY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_ACK_STATUS = 2;
  localparam int ST_START_SEEN = 3;
  localparam int ST_STOP_SEEN = 4;
  localparam int ST_SLAVE_READ = 5;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_GENCALL = 7;
  localparam int ST_BUS_BUSY = 8;
  localparam int ST_SLAVE_ACTIVE = 9;
  localparam int ST_COLLISION = 10;

  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] TX_BITS = 4'h9;
  localparam logic [3:0] ACK_BITS = 4'h1;

  typedef struct packed {
    logic enable;
    logic [1:0] rsv_hi;
    logic clock_release;
    logic [1:0] rsv_mid;
    logic ten_bit;
    logic rsv_lo;
    logic general_call_enable;
    logic stretch_enable;
    logic ack_value;
    logic ack_sequence_request;
    logic receive_byte_request;
    logic stop_request;
    logic restart_request;
    logic start_request;
  } ims_ctrl_s;

  typedef struct packed {
    logic [8:0] rsv;
    logic stop_irq_enable;
    logic start_irq_enable;
    logic buffer_overwrite_enable;
    logic hold_time_select;
    logic slave_collision_detect_enable;
    logic address_hold_enable;
    logic data_hold_enable;
  } ims_opts_s;

  typedef enum logic [3:0] {M_IDLE, M_S1, M_S2, M_R1, M_R2, M_R3, M_P1, M_P2, M_P3, M_LO, M_HI} ims_mstate_e;
  typedef enum logic [1:0] {X_TX, X_RX, X_ACK} ims_xfer_e;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RXD, S_TXD, S_MACK} ims_sstate_e;

  // byte-lane write of a 16-bit register; only writable bits change
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
    return (old & ~m) | (dat[15:0] & m);
  endfunction

endpackage

// ==== tb/ims_bus_model.sv ====
// remote I2C slave on the open-drain wires
`timescale 1ns/1ps
module ims_bus_model
#(
  parameter logic [6:0] DEV = 7'h52,
  parameter logic [7:0] RD_BYTE = 8'h3C,
  parameter int HOLD_NS = 10,
  parameter int STRETCH_NS = 100
)
(
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] last_byte,
  output logic ack_seen
);
  int n = 0;
  logic rd, first;
  logic [7:0] sh;
  initial {scl_pull, sda_pull, rd, first, ack_seen, last_byte, sh} = 21'h0;
  always @(negedge sda)
    if (scl)
    begin
      n = 0;
      rd = 1'b0;
      first = 1'b1;
    end
  always @(posedge scl)
  begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && rd) ack_seen = sda;
    n = n + 1;
    if (n == 8) last_byte = sh;
  end
  // data moves a hold time after the fall, so the controller never sees it beside a clock edge
  always @(negedge scl)
  begin
    scl_pull = n == 8 && !rd;
    #(HOLD_NS);
    if (n == 8 && !rd)
    begin
      sda_pull = !first || sh[7:1] == DEV;
      #(STRETCH_NS) scl_pull = 1'b0;
    end
    else if (n == 9)
    begin
      if (first) rd = sh[0] && sh[7:1] == DEV;
      else if (ack_seen) rd = 1'b0;
      n = 0;
      first = 1'b0;
      sda_pull = rd && !RD_BYTE[7];
    end
    else sda_pull = rd && n < 8 && !RD_BYTE[7 - n];
  end
endmodule

// ==== tb/ims_ctrl_asserts.sv ====
// port assertions for the I2C controller
`timescale 1ns/1ps
module ims_ctrl_asserts
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic evt_master
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  read_upper_a: assert property (wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin value not low");
  start_clock_a: assert property ($rose(sda_oe) && scl_i && !scl_oe |-> ##[1:1000] scl_oe)
    else $error("no clock after start");
  start_data_a: assert property ($rose(sda_oe) && scl_i && !scl_oe |=> sda_oe [*4])
    else $error("data lost after start");
  stop_idle_a: assert property ($fell(sda_oe) && scl_i && !scl_oe |=> !scl_oe [*4])
    else $error("clock pulled after stop");
  evt_pulse_a: assert property (evt_master |=> !evt_master)
    else $error("long master event");
endmodule
bind ims_ctrl ims_ctrl_asserts u_chk (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .evt_master(evt_master));

// ==== tb/ims_ctrl_tb.sv ====
// bench: register access and master transfers against a remote slave
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %0h, expected %0h", $time, (a), (b)); end end
module ims_ctrl_tb
  import ims_pkg::*;
;
  // half period of 50 cycles outlasts the 20-cycle data hold; the model wires add no path delay to take off
  localparam logic [15:0] RELOAD = 16'h0030;
  localparam logic [6:0] DEV = 7'h52;
  localparam logic [7:0] RD_BYTE = 8'h3C;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, scl_o, scl_oe, sda_o, sda_oe, evt_master, evt_slave, evt_collision;
  logic scl_pull, sda_pull, ack_seen;
  logic [7:0] last_byte;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int slave_evts = 0;
  int coll_evts = 0;
  time t0;
  wire scl = !(scl_oe || scl_pull);
  wire sda = !(sda_oe || sda_pull);
  always #2.5 clock = ~clock;
  ims_ctrl dut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .evt_master(evt_master), .evt_slave(evt_slave), .evt_collision(evt_collision));
  // the remote slave stretches past the low half, so the high half must wait for it
  ims_bus_model #(.DEV(DEV), .RD_BYTE(RD_BYTE), .STRETCH_NS(400)) peer (.scl(scl), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .last_byte(last_byte), .ack_seen(ack_seen));
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    `CHK(q & m, e)
  endtask
  task automatic wait_evt;
    @(posedge clock);
    while (evt_master !== 1'b1) @(posedge clock);
  endtask
  task final_report;
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (evt_slave === 1'b1)
      slave_evts++;
    if (evt_collision === 1'b1)
      coll_evts++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    rc(ADDR_CTRL, 16'hFFFF, CTRL_RESET);
    rc(ADDR_OPTS, 16'hFFFF, OPTS_RESET);
    rc(ADDR_BAUD, 16'hFFFF, BAUD_RESET);
    wr(8'h1C, 16'hFFFF);
    rc(8'h1C, 16'hFFFF, 16'h0000);
    wr(ADDR_OPTS, 16'hFFFF);
    rc(ADDR_OPTS, 16'hFFFF, OPTS_WMASK);
    wr(ADDR_OPTS, 16'h0060);
    wr(ADDR_BAUD, RELOAD);
    wr(ADDR_CTRL, 16'h9000);
    wr(ADDR_CTRL, 16'h9001);
    wait_evt();
    rc(ADDR_CTRL, 16'hFFFF, 16'h9000);
    wr(ADDR_TX, {8'h00, DEV, 1'b0});
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    `CHK($time - t0, 64'(2 * (RELOAD + 2) * CLK_PERIOD_NS))
    wait_evt();
    `CHK(last_byte, {DEV, 1'b0})
    rc(ADDR_STAT, 16'h0004, 16'h0000);
    wr(ADDR_CTRL, 16'h9002);
    wait_evt();
    rc(ADDR_CTRL, 16'hFFFF, 16'h9000);
    wr(ADDR_TX, {8'h00, DEV, 1'b1});
    wait_evt();
    wr(ADDR_CTRL, 16'h9008);
    wait_evt();
    rc(ADDR_CTRL, 16'hFFFF, 16'h9000);
    rc(ADDR_RX, 16'h00FF, {8'h00, RD_BYTE});
    wr(ADDR_CTRL, 16'h9030);
    wait_evt();
    `CHK(ack_seen, 1'b1)
    rc(ADDR_CTRL, 16'hFFFF, 16'h9020);
    wr(ADDR_CTRL, 16'h9004);
    wait_evt();
    rc(ADDR_CTRL, 16'hFFFF, 16'h9000);
    `CHK({scl, sda}, 2'b11)
    `CHK(slave_evts, 3)
    `CHK(coll_evts, 0)
    final_report();
  end
endmodule
